// ==== vcr_regs.sv ====
// module: control and status register bank of the coil driver, behind the serial byte engine
//
// Behaviour
// [RULE1] writing one to control bit 0 restores all register defaults and enters standby; the pointer is not reset and steps on to 03
// [RULE2] the soft reset bit clears itself, so it always reads back zero
// [RULE3] control bit 1 enables ringing compensation, resets to one; bits 7..2 read zero
// [RULE4] coil current code is unsigned 10 bits, 0.1 mA per step up to 102.3 mA
// [RULE5] high current register holds code bits 9..8 in bits 1..0; others zero
// [RULE6] low current register holds code bits 7..0, read/write, resets to zero
// [RULE7] new current is applied only after a low byte write; high alone changes nothing
// [RULE8] host writes high then low current byte whenever it sets a new current
// [RULE9] all status flags clear when the device moves from standby to active
// [RULE10] thermal shutdown forces standby and blocks activation until the condition clears
// [RULE11] status bits: thermal 4, short 3, open 2, undervoltage 1, overcurrent 0
// [RULE12] each detected fault sets its sticky status flag; flags reset to zero
// [RULE13] register pointer advances by one after each acknowledged data byte
// [RULE14] writes to read-only, unused or unmapped bits are ignored
`timescale 1ns/1ps

module vcr_regs (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // byte engine side, same clock domain
    input wire logic sub_addr_valid,
    input wire logic [7:0] sub_addr,
    input wire logic wr_valid,
    input wire logic [7:0] wr_data,
    input wire logic rd_ack,
    output logic [7:0] rd_data,
    output logic [7:0] reg_pointer,
    // detector and enable pins, asynchronous
    input wire logic overcurrent_det,
    input wire logic undervoltage_det,
    input wire logic coil_open_det,
    input wire logic coil_short_det,
    input wire logic thermal_det,
    input wire logic active_req,
    // driver stage side
    output logic [vcr_pkg::COIL_CODE_WIDTH-1:0] coil_current_code,
    output logic ring_comp_en,
    output logic device_active
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    localparam int SYNC_W = vcr_pkg::STAT_FLAG_COUNT + 1;

    typedef struct packed {
        logic [SYNC_W-1:0] sync1;
        logic [SYNC_W-1:0] sync2;
        vcr_pkg::vcr_state_e pstate;
        logic [7:0] pointer;
        logic ring_en;
        logic [vcr_pkg::HIGH_FIELD_WIDTH-1:0] cur_high;
        logic [7:0] cur_low;
        logic [vcr_pkg::COIL_CODE_WIDTH-1:0] applied;
        logic [vcr_pkg::STAT_FLAG_COUNT-1:0] flags;
        logic [7:0] rd_data;
    } vcr_regs_s;

    vcr_regs_s state_q;
    vcr_regs_s state_d;

    // ------------------------------------------------------------
    // read decode, used for the read data register
    // ------------------------------------------------------------
    function automatic logic [7:0] read_reg(input logic [7:0] addr, input vcr_regs_s s);
        logic [7:0] v;
        v = 8'h00;
        case (addr)
            vcr_pkg::ADDR_CONTROL: begin
                // reset bit always reads zero, bits 7..2 zero
                v[vcr_pkg::CTRL_RING_EN_BIT] = s.ring_en; // RULE2 RULE3
            end
            vcr_pkg::ADDR_COIL_CURRENT_HIGH: begin
                v[vcr_pkg::HIGH_FIELD_WIDTH-1:0] = s.cur_high; // RULE5
            end
            vcr_pkg::ADDR_COIL_CURRENT_LOW: begin
                v = s.cur_low; // RULE6
            end
            vcr_pkg::ADDR_STATUS: begin
                v[vcr_pkg::STAT_FLAG_COUNT-1:0] = s.flags; // RULE11
            end
            default: begin
                v = 8'h00;
            end
        endcase
        return v;
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [vcr_pkg::STAT_FLAG_COUNT-1:0] events;
        logic thermal_now;
        logic req_now;
        logic soft_reset;
        logic go_active;
        events = '0;
        thermal_now = 1'b0;
        req_now = 1'b0;
        soft_reset = 1'b0;
        go_active = 1'b0;
        state_d = state_q;

        // two-stage synchronisers on detector and enable pins
        state_d.sync1 = {active_req, thermal_det, coil_short_det, coil_open_det,
                         undervoltage_det, overcurrent_det};
        state_d.sync2 = state_q.sync1;
        events[vcr_pkg::STAT_OVERCURRENT_BIT] = state_q.sync2[0];
        events[vcr_pkg::STAT_UNDERVOLTAGE_BIT] = state_q.sync2[1];
        events[vcr_pkg::STAT_COIL_OPEN_BIT] = state_q.sync2[2];
        events[vcr_pkg::STAT_COIL_SHORT_BIT] = state_q.sync2[3];
        events[vcr_pkg::STAT_THERMAL_BIT] = state_q.sync2[4];
        thermal_now = state_q.sync2[4];
        req_now = state_q.sync2[5];

        // pointer load and register writes
        if (sub_addr_valid) begin
            state_d.pointer = sub_addr;
        end else if (wr_valid) begin
            case (state_q.pointer)
                vcr_pkg::ADDR_CONTROL: begin
                    // soft reset is a strobe only, never stored
                    soft_reset = wr_data[vcr_pkg::CTRL_SOFT_RESET_BIT]; // RULE1 RULE2
                    state_d.ring_en = wr_data[vcr_pkg::CTRL_RING_EN_BIT]; // RULE3
                end
                vcr_pkg::ADDR_COIL_CURRENT_HIGH: begin
                    // held until the low byte lands, the drive stays put
                    state_d.cur_high = wr_data[vcr_pkg::HIGH_FIELD_WIDTH-1:0]; // RULE5 RULE7
                end
                vcr_pkg::ADDR_COIL_CURRENT_LOW: begin
                    state_d.cur_low = wr_data; // RULE6
                    state_d.applied = {state_q.cur_high, wr_data}; // RULE4 RULE7 RULE8
                end
                default: begin
                    // status and unmapped offsets take nothing
                    state_d.pointer = state_q.pointer; // RULE14
                end
            endcase
            state_d.pointer = state_q.pointer + 8'h01; // RULE13
        end else if (rd_ack) begin
            state_d.pointer = state_q.pointer + 8'h01; // RULE13
        end

        // power state; thermal trip overrides a pending request
        go_active = (state_q.pstate == vcr_pkg::ST_STANDBY) && req_now && !thermal_now;
        case (state_q.pstate)
            vcr_pkg::ST_STANDBY: begin
                if (go_active) begin
                    state_d.pstate = vcr_pkg::ST_ACTIVE; // RULE10
                end
            end
            vcr_pkg::ST_ACTIVE: begin
                if (thermal_now || !req_now) begin
                    state_d.pstate = vcr_pkg::ST_STANDBY; // RULE10
                end
            end
            default: begin
                state_d.pstate = vcr_pkg::ST_STANDBY;
            end
        endcase

        // flags: clear on activation, but a same-cycle event still sets
        if (go_active) begin
            state_d.flags = '0; // RULE9
        end
        state_d.flags = state_d.flags | events; // RULE12

        // soft reset returns the control, current and status registers to default and forces standby; the pointer still advances
        if (soft_reset) begin
            state_d.pstate = vcr_pkg::ST_STANDBY; // RULE1
            state_d.ring_en = vcr_pkg::RST_CONTROL[vcr_pkg::CTRL_RING_EN_BIT]; // RULE1
            state_d.cur_high = vcr_pkg::RST_COIL_CURRENT_HIGH[vcr_pkg::HIGH_FIELD_WIDTH-1:0];
            state_d.cur_low = vcr_pkg::RST_COIL_CURRENT_LOW; // RULE1
            state_d.applied = '0;
            state_d.flags = vcr_pkg::RST_STATUS[vcr_pkg::STAT_FLAG_COUNT-1:0] | events;
        end

        // read data tracks the pointer of the next cycle
        state_d.rd_data = read_reg(state_d.pointer, state_d);
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (srst) begin
            state_q.sync1 <= '0;
            state_q.sync2 <= '0;
            state_q.pstate <= vcr_pkg::ST_STANDBY;
            state_q.pointer <= vcr_pkg::RST_POINTER;
            state_q.ring_en <= vcr_pkg::RST_CONTROL[vcr_pkg::CTRL_RING_EN_BIT];
            state_q.cur_high <= vcr_pkg::RST_COIL_CURRENT_HIGH[vcr_pkg::HIGH_FIELD_WIDTH-1:0];
            state_q.cur_low <= vcr_pkg::RST_COIL_CURRENT_LOW;
            state_q.applied <= '0;
            state_q.flags <= vcr_pkg::RST_STATUS[vcr_pkg::STAT_FLAG_COUNT-1:0];
            state_q.rd_data <= 8'h00;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // outputs, all straight from flops
    // ------------------------------------------------------------
    assign rd_data = state_q.rd_data;
    assign reg_pointer = state_q.pointer;
    assign coil_current_code = state_q.applied;
    assign ring_comp_en = state_q.ring_en;
    assign device_active = (state_q.pstate == vcr_pkg::ST_ACTIVE);

endmodule

// ==== vcr_pkg.sv ====
// package: register map, field positions and reset values of the coil driver register bank
package vcr_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CONTROL = 8'h02;
    localparam logic [7:0] ADDR_COIL_CURRENT_HIGH = 8'h03;
    localparam logic [7:0] ADDR_COIL_CURRENT_LOW = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h05;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_CONTROL = 8'h02;
    localparam logic [7:0] RST_COIL_CURRENT_HIGH = 8'h00;
    localparam logic [7:0] RST_COIL_CURRENT_LOW = 8'h00;
    localparam logic [7:0] RST_STATUS = 8'h00;
    localparam logic [7:0] RST_POINTER = 8'h00;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTRL_SOFT_RESET_BIT = 0;
    localparam int CTRL_RING_EN_BIT = 1;
    localparam int HIGH_FIELD_WIDTH = 2;
    localparam int STAT_OVERCURRENT_BIT = 0;
    localparam int STAT_UNDERVOLTAGE_BIT = 1;
    localparam int STAT_COIL_OPEN_BIT = 2;
    localparam int STAT_COIL_SHORT_BIT = 3;
    localparam int STAT_THERMAL_BIT = 4;
    localparam int STAT_FLAG_COUNT = 5;

    // ------------------------------------------------------------
    // current scale: one code step is 100 uA, full code 102.3 mA
    // ------------------------------------------------------------
    localparam int COIL_CODE_WIDTH = 10;
    localparam int COIL_STEP_UA = 100;
    localparam int COIL_FULL_SCALE_UA = ((1 << COIL_CODE_WIDTH) - 1) * COIL_STEP_UA;

    // ------------------------------------------------------------
    // power state
    // ------------------------------------------------------------
    typedef enum logic {
        ST_STANDBY,
        ST_ACTIVE
    } vcr_state_e;

endpackage

// ==== vcr_host_model.sv ====
// host side model: drives pointer loads, write bytes and read acknowledges
`timescale 1ns/1ps
module vcr_host_model (
    // clock
    input wire logic clock,
    // requests to the register bank
    output logic sub_addr_valid,
    output logic [7:0] sub_addr,
    output logic wr_valid,
    output logic [7:0] wr_data,
    output logic rd_ack
);
    initial {sub_addr_valid, sub_addr, wr_valid, wr_data, rd_ack} = '0;
    // kind 0 loads the pointer, 1 writes a byte, 2 acknowledges a read
    task automatic req(input int k, input logic [7:0] v);
        @(posedge clock);
        #2;
        if (k == 0) sub_addr = v;
        if (k == 1) wr_data = v;
        sub_addr_valid = (k == 0);
        wr_valid = (k == 1);
        rd_ack = (k == 2);
        @(posedge clock);
        #2;
        {sub_addr_valid, wr_valid, rd_ack} = '0;
        // released bytes flip so a stale value is never mistaken for data
        sub_addr = ~sub_addr;
        wr_data = ~wr_data;
    endtask
    task automatic set_current(input logic [9:0] c);
        req(0, 8'h03);
        req(1, {6'h00, c[9:8]});
        req(1, c[7:0]);
    endtask
endmodule

// ==== vcr_regs_properties.sv ====
// assertions on the ports of the coil driver register bank
`timescale 1ns/1ps
module vcr_regs_properties (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // requests
    input wire logic sub_addr_valid,
    input wire logic [7:0] sub_addr,
    input wire logic wr_valid,
    input wire logic [7:0] wr_data,
    input wire logic rd_ack,
    input wire logic thermal_det,
    // answers
    input wire logic [7:0] rd_data,
    input wire logic [7:0] reg_pointer,
    input wire logic [vcr_pkg::COIL_CODE_WIDTH-1:0] coil_current_code,
    input wire logic ring_comp_en,
    input wire logic device_active
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    // a write byte taken at a given pointer
    sequence s_wr(a);
        wr_valid && !sub_addr_valid && reg_pointer == a;
    endsequence
    a_pointer_load: assert property (
        sub_addr_valid |=> reg_pointer == $past(sub_addr)) else $error("pointer not loaded");
    a_pointer_step: assert property (
        !sub_addr_valid && (wr_valid || rd_ack) |=> reg_pointer == $past(reg_pointer) + 8'h01)
        else $error("pointer did not advance");
    a_high_hold: assert property (
        s_wr(8'h03) |=> $stable(coil_current_code)) else $error("high byte moved current");
    a_low_apply: assert property (
        s_wr(8'h04) |=> coil_current_code[7:0] == $past(wr_data)) else $error("low not applied");
    a_soft_reset: assert property (
        s_wr(8'h02) ##0 wr_data[0] |=> coil_current_code == '0 && ring_comp_en && !device_active)
        else $error("soft reset incomplete");
    a_ring_write: assert property (
        s_wr(8'h02) ##0 !wr_data[0] |=> ring_comp_en == $past(wr_data[1]))
        else $error("ring enable not written");
    a_ctrl_read: assert property (
        reg_pointer == 8'h02 |-> rd_data == {6'h00, ring_comp_en, 1'b0}) else $error("control read");
    a_high_read: assert property (
        reg_pointer == 8'h03 |-> rd_data[7:2] == 6'h00) else $error("high unused bits set");
    a_status_read: assert property (
        reg_pointer == 8'h05 |-> rd_data[7:5] == 3'h0) else $error("status unused bits set");
    a_thermal_block: assert property (
        thermal_det [*4] |=> !device_active) else $error("active during thermal trip");
endmodule
bind vcr_regs vcr_regs_properties u_vcr_regs_properties (.clock, .srst, .sub_addr_valid,
    .sub_addr, .wr_valid, .wr_data, .rd_ack, .thermal_det(thermal_det), .rd_data, .reg_pointer,
    .coil_current_code, .ring_comp_en, .device_active);

// ==== vcr_regs_test.sv ====
// self-checking bench for the coil driver register bank
`timescale 1ns/1ps
module vcr_regs_test;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic sub_addr_valid, wr_valid, rd_ack;
    logic [7:0] sub_addr, wr_data, rd_data, reg_pointer;
    logic [4:0] faults = 5'h00;
    logic active_req = 1'b0;
    logic [9:0] coil_current_code;
    logic ring_comp_en, device_active;
    int fails = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #12.5 clock = ~clock;
    vcr_host_model u_vcr_host_model (.clock, .sub_addr_valid, .sub_addr, .wr_valid, .wr_data,
        .rd_ack);
    vcr_regs u_vcr_regs (.clock, .srst, .sub_addr_valid, .sub_addr, .wr_valid, .wr_data, .rd_ack,
        .rd_data, .reg_pointer, .overcurrent_det(faults[0]), .undervoltage_det(faults[1]),
        .coil_open_det(faults[2]), .coil_short_det(faults[3]), .thermal_det(faults[4]),
        .active_req, .coil_current_code, .ring_comp_en, .device_active);
    task automatic end_of_test;
        $display("compared %0d mismatched %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] e);
        chk({2'h0, rd_data}, {2'h0, e});
        u_vcr_host_model.req(2, 8'h00);
    endtask
    // synchroniser delay plus margin for the flag and read path
    task automatic settle;
        repeat (6) @(posedge clock);
        #2;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic test_defaults;
        chk({ring_comp_en, device_active, coil_current_code[7:0]}, 10'h200);
        u_vcr_host_model.req(0, 8'h02);
        rd(8'h02);
        rd(8'h00);
        rd(8'h00);
        rd(8'h00);
        $display("test_defaults done");
    endtask
    task automatic test_current;
        u_vcr_host_model.req(0, 8'h03);
        u_vcr_host_model.req(1, 8'hFF);
        chk(coil_current_code, 10'h000);
        u_vcr_host_model.req(0, 8'h03);
        rd(8'h03);
        u_vcr_host_model.set_current(10'h3FF);
        chk(coil_current_code, 10'h3FF);
        u_vcr_host_model.set_current(10'h155);
        chk(coil_current_code, 10'h155);
        $display("test_current done");
    endtask
    task automatic test_faults;
        u_vcr_host_model.req(0, 8'h05);
        for (int i = 0; i < 5; i++) begin
            faults[i] = 1'b1;
            settle();
            chk({2'h0, rd_data}, 10'((1 << (i + 1)) - 1));
        end
        active_req = 1'b1;
        u_vcr_host_model.req(1, 8'h00);
        u_vcr_host_model.req(0, 8'h05);
        settle();
        chk({rd_data, 1'b0, device_active}, 10'h07C);
        faults = 5'h00;
        settle();
        chk({rd_data, 1'b0, device_active}, 10'h001);
        $display("test_faults done");
    endtask
    task automatic test_soft_reset;
        u_vcr_host_model.req(0, 8'h02);
        u_vcr_host_model.req(1, 8'h00);
        chk({9'h000, ring_comp_en}, 10'h000);
        u_vcr_host_model.req(0, 8'h02);
        u_vcr_host_model.req(1, 8'h01);
        chk({ring_comp_en, device_active, coil_current_code[7:0]}, 10'h200);
        u_vcr_host_model.req(0, 8'h02);
        rd(8'h02);
        rd(8'h00);
        rd(8'h00);
        $display("test_soft_reset done");
    endtask
    initial begin
        repeat (16) @(posedge clock);
        #2;
        srst = 1'b0;
        test_defaults();
        test_current();
        test_faults();
        test_soft_reset();
        end_of_test();
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            $display("[FAIL] %0t run too long", $time);
            end_of_test();
        end
    end
endmodule
